// file: logic/cfs_frame_writer.sv
/*
  Device-side frame write logic behind the parallel configuration port:
  sync/abort detection, command and frame address registers, word holding,
  frame staging and address advance across main-segment column boundaries.
  Assumes the host drives port pins changing off its own port clock, which
  is sampled here by ref_clk_in through two flip-flops.
*/
// Functional notes
// [R1] Memory has three segments: main plus two block-memory segments.
// [R2] Block-memory segments are addressed apart, needing separate operations.
// [R3] Host avoids block-memory access after configuration.
// [R4] User flip-flops lie outside configuration memory, untouched by writes.
// [R5] Host never partially rewrites designs using tables as memory or shifters.
// [R6] One frame is the smallest readable or writable unit.
// [R7] Main segment: centre 8, logic 48, two bram-ic 27, two io 54 frames.
// [R8] Even columns sit left of centre, odd columns right.
// [R9] Frames numbered from centre outward within each column.
// [R10] Host loads frame address, then word count, then data.
// [R11] Word count covers frames, dummy words, and one dummy frame.
// [R12] First frame at loaded address, address advances one frame each.
// [R13] Words fill a one-frame staging register, written whole when full.
// [R14] Last word is held back; only the next word pushes it on.
// [R15] Frame address holds segment type, major column and minor frame.
// [R16] Host uses segment 00 for main and zeros unused bits.
// [R17] Major in bits 17..24, minor in bits 9..16; zero is first frame.
// [R18] Host rewrites only the upset frame when correcting.
// [R19] Host scrubs the whole main segment periodically, up to 400 Mbit/s.
// [R20] Host keeps 16-bit CRC per frame and compares on readback.
// [R21] Chip select low with write high for three port clocks aborts.
// [R22] Host resynchronises with the sync word after abort.
// [R23] Host opens data writes with a type-one header counting words.
// [R24] Host records every mismatching frame of a readback pass.
// [R25] Host times scrubs with an interval counter, never overlapping.
// [R26] Host resets CRC each frame, excluding the dummy word.
`timescale 1ns/100ps
`default_nettype none
module cfs_frame_writer
  import cfs_pkg::*;
(
  // System
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Configuration port pins
  input  wire logic        port_clk_in,
  input  wire logic        chip_sel_n_in,
  input  wire logic        write_n_in,
  input  wire logic [31:0] port_data_in,
  // Frame write to the configuration latches
  output logic             frame_we_out,
  output cfs_frame_s       frame_out,
  // Status
  output logic             synced_out,
  output logic             write_mode_out,
  output logic             aborted_out
);

  // Two-stage synchronisers; port pins change off the host clock
  logic [1:0]  clk_s_q;
  logic        clk_d_q;
  logic [1:0]  cs_s_q;
  logic [1:0]  wr_s_q;
  logic [31:0] dat_s1_q;
  logic [31:0] dat_s2_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      clk_s_q  <= 2'h0;
      clk_d_q  <= 1'b0;
      cs_s_q   <= 2'h3;
      wr_s_q   <= 2'h3;
      dat_s1_q <= 32'h0;
      dat_s2_q <= 32'h0;
    end else begin
      clk_s_q  <= {clk_s_q[0], port_clk_in};
      clk_d_q  <= clk_s_q[1];
      cs_s_q   <= {cs_s_q[0], chip_sel_n_in};
      wr_s_q   <= {wr_s_q[0], write_n_in};
      dat_s1_q <= port_data_in;
      dat_s2_q <= dat_s1_q;
    end
  end

  logic port_rise;
  logic word_stb;
  logic abort_cyc;
  assign port_rise = clk_s_q[1] & ~clk_d_q;
  assign word_stb  = port_rise & ~cs_s_q[1] & ~wr_s_q[1];
  assign abort_cyc = port_rise & ~cs_s_q[1] & wr_s_q[1];

  // Frames in a column of the main segment, by column number
  function automatic logic [7:0] col_frames(input logic [7:0] maj);
    if (maj == 8'h00)
      col_frames = FR_CENTER;
    else if (maj <= LOGIC_COLS)
      col_frames = FR_LOGIC;
    else if (maj <= LOGIC_COLS + 8'h02)
      col_frames = FR_IO;
    else
      col_frames = FR_BRAM_IC;
  endfunction

  // Abort: three consecutive port clocks with select low and write high
  logic [1:0] abort_cnt_q;
  logic       abort_hit;
  assign abort_hit = abort_cyc && (abort_cnt_q == 2'(ABORT_CYC - 1));

  always_ff @(posedge ref_clk_in) begin
    if (rst_in)
      abort_cnt_q <= 2'h0;
    else if (port_rise && (cs_s_q[1] || !wr_s_q[1]))
      abort_cnt_q <= 2'h0;
    else if (abort_cyc && abort_cnt_q != 2'(ABORT_CYC - 1))
      abort_cnt_q <= abort_cnt_q + 2'h1; // R21
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in)
      aborted_out <= 1'b0;
    else if (abort_hit)
      aborted_out <= 1'b1;
    else if (word_stb && dat_s2_q == SYNC_WORD)
      aborted_out <= 1'b0;
  end

  // Packet state machine
  cfs_state_e  state_q;
  logic [10:0] words_q;
  logic        write_config_command_q;
  cfs_addr_s   far_q;
  logic [31:0] hold_q;
  logic        hold_v_q;
  logic [FRAME_WORDS*32-1:0] stage_q;
  logic [FW_CW-1:0]          fill_q;
  logic        stage_full;
  assign stage_full = word_stb && state_q == ST_DATA && hold_v_q
                      && fill_q == FW_CW'(FRAME_WORDS);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || abort_hit) begin
      state_q <= ST_UNSYNC;
      words_q <= 11'h0;
      write_config_command_q  <= 1'b0;
    end else if (word_stb) begin
      case (state_q)
        ST_UNSYNC: if (dat_s2_q == SYNC_WORD) state_q <= ST_IDLE;
        ST_IDLE: begin
          if (dat_s2_q == HDR_CMD)
            state_q <= ST_CMD;
          else if (dat_s2_q == HDR_FAR)
            state_q <= ST_FAR;
          else if ((dat_s2_q & HDR_HI_MASK) == HDR_FRAME_DATA_INPUT_REGISTER_HI && write_config_command_q) begin
            state_q <= ST_DATA; // R23
            words_q <= dat_s2_q[10:0] & HDR_CNT_MSK;
          end
        end
        ST_CMD: begin
          if (dat_s2_q == CMD_WRITE_CONFIG_COMMAND)
            write_config_command_q <= 1'b1;
          else if (dat_s2_q == CMD_RESET_CRC_COMMAND)
            write_config_command_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        ST_FAR: state_q <= ST_IDLE;
        ST_DATA: begin
          words_q <= words_q - 11'h1;
          if (words_q == 11'h1)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_UNSYNC;
      endcase
    end
  end

  // Frame address register: segment, major column, minor frame
  always_ff @(posedge ref_clk_in) begin
    if (rst_in)
      far_q <= '0;
    else if (word_stb && state_q == ST_FAR && !abort_hit) begin
      far_q.seg   <= dat_s2_q[SEG_LSB +: SEG_W]; // R15 R1
      far_q.major <= dat_s2_q[MAJ_LSB +: MAJ_W]; // R17
      far_q.minor <= dat_s2_q[MIN_LSB +: MIN_W]; // R17
    end else if (frame_we_out) begin
      // Advance one frame; in the main segment, step to the next column at its end
      if (far_q.seg == SEG_MAIN
          && far_q.minor == col_frames(far_q.major) - 8'h01) begin // R7 R9
        far_q.minor <= 8'h00;
        far_q.major <= far_q.major + 8'h01; // R8
      end else begin
        far_q.minor <= far_q.minor + 8'h01; // R12 R2
      end
    end
  end

  // Hold-back word and staging register; a word moves on only when the next arrives
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || abort_hit) begin
      hold_q   <= 32'h0;
      hold_v_q <= 1'b0;
      stage_q  <= '0;
      fill_q   <= '0;
    end else if (word_stb && state_q == ST_DATA) begin
      hold_q   <= dat_s2_q; // R14
      // The pad word after each frame only pushes; it never enters staging
      hold_v_q <= fill_q != FW_CW'(FRAME_WORDS); // R11
      if (hold_v_q)
        stage_q <= {hold_q, stage_q[FRAME_WORDS*32-1:32]}; // R13
      if (fill_q == FW_CW'(FRAME_WORDS))
        fill_q <= '0;
      else
        fill_q <= fill_q + FW_CW'(1);
    end else if (state_q != ST_DATA) begin
      hold_v_q <= 1'b0;
      fill_q   <= '0;
    end
  end

  // Whole-frame parallel write; user flip-flops are never on this path
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      frame_we_out <= 1'b0;
      frame_out    <= '0;
    end else begin
      frame_we_out <= stage_full && !abort_hit; // R6 R4
      if (stage_full) begin
        frame_out.addr <= far_q;
        frame_out.data <= {hold_q, stage_q[FRAME_WORDS*32-1:32]}; // R13
      end
    end
  end

  // Abort drops status in the same cycle that raises aborted_out
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || abort_hit) begin
      synced_out     <= 1'b0;
      write_mode_out <= 1'b0;
    end else begin
      synced_out     <= state_q != ST_UNSYNC;
      write_mode_out <= write_config_command_q;
    end
  end

endmodule // cfs_frame_writer
`default_nettype wire

// file: logic/cfs_pkg.sv
/*
  Constants and carrier types for the configuration frame write path.
  Assumes a single 10 MHz system clock; the port clock arrives as a pin.
*/
`default_nettype none
package cfs_pkg;
  // Segment-type field and address field positions
  localparam int          SEG_LSB     = 25;
  localparam int          SEG_W       = 2;
  localparam int          MAJ_LSB     = 17;
  localparam int          MAJ_W       = 8;
  localparam int          MIN_LSB     = 9;
  localparam int          MIN_W       = 8;
  localparam logic [1:0]  SEG_MAIN    = 2'h0;
  localparam logic [1:0]  SEG_BRAM_A  = 2'h1;
  localparam logic [1:0]  SEG_BRAM_B  = 2'h2;
  // Column frame counts in the main segment
  localparam logic [7:0]  FR_CENTER   = 8'h08;
  localparam logic [7:0]  FR_LOGIC    = 8'h30;
  localparam logic [7:0]  FR_BRAM_IC  = 8'h1b;
  localparam logic [7:0]  FR_IO       = 8'h36;
  // Device geometry (frame length in words, logic column count)
  localparam int          FRAME_WORDS = 4;
  localparam logic [7:0]  LOGIC_COLS  = 8'h04;
  localparam int          FW_CW       = 3;
  // Packet words seen on the configuration port
  localparam logic [31:0] SYNC_WORD   = 32'haa995566;
  localparam logic [31:0] HDR_CMD     = 32'h30008001;
  localparam logic [31:0] HDR_FAR     = 32'h30002001;
  localparam logic [31:0] HDR_FRAME_DATA_INPUT_REGISTER_HI = 32'h30004000;
  localparam logic [31:0] CMD_WRITE_CONFIG_COMMAND    = 32'h00000001;
  localparam logic [31:0] CMD_RESET_CRC_COMMAND    = 32'h00000007;
  localparam logic [31:0] HDR_HI_MASK = 32'hfffff800;
  localparam logic [10:0] HDR_CNT_MSK = 11'h7ff;
  localparam int          ABORT_CYC   = 3;

  typedef enum logic [2:0] {
    ST_UNSYNC = 3'b000,
    ST_IDLE   = 3'b001,
    ST_CMD    = 3'b011,
    ST_FAR    = 3'b010,
    ST_DATA   = 3'b110
  } cfs_state_e;

  typedef struct packed {
    logic [1:0] seg;
    logic [7:0] major;
    logic [7:0] minor;
  } cfs_addr_s;

  typedef struct packed {
    cfs_addr_s                      addr;
    logic [FRAME_WORDS*32-1:0]      data;
  } cfs_frame_s;
endpackage : cfs_pkg
`default_nettype wire

// file: tb/cfs_frame_writer_sva.sv
/* Port checker for the frame writer.
   Assumes one clock domain and binding onto cfs_frame_writer. */
`timescale 1ns/100ps
`default_nettype none
module cfs_frame_writer_sva
  import cfs_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       frame_we_out,
  input wire cfs_frame_s frame_out,
  input wire logic       synced_out,
  input wire logic       write_mode_out,
  input wire logic       aborted_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_we_spacing: assert property (frame_we_out |=> !frame_we_out [*8])
    else $error("frame writes too close");
  a_we_wmode: assert property (frame_we_out |-> $past(write_mode_out))
    else $error("frame write outside write mode");
  a_we_synced: assert property (frame_we_out |-> synced_out && !aborted_out)
    else $error("frame write while unsynced");
  a_abort_clears: assert property (aborted_out |-> !synced_out && !write_mode_out)
    else $error("abort left state behind");
  a_wmode_synced: assert property (write_mode_out |-> synced_out)
    else $error("write mode without sync");
  a_frame_hold: assert property ($changed(frame_out) |-> frame_we_out)
    else $error("frame changed without write");
  a_centre_range: assert property (frame_we_out && frame_out.addr.seg == SEG_MAIN
    && frame_out.addr.major == 8'h00 |-> frame_out.addr.minor < FR_CENTER)
    else $error("centre minor out of range");
  a_logic_range: assert property (frame_we_out && frame_out.addr.seg == SEG_MAIN
    && frame_out.addr.major inside {[8'h01:LOGIC_COLS]} |-> frame_out.addr.minor < FR_LOGIC)
    else $error("logic minor out of range");
  c_write: cover property (frame_we_out);
  c_abort: cover property ($rose(aborted_out));
  c_sync: cover property ($rose(synced_out));
endmodule // cfs_frame_writer_sva
bind cfs_frame_writer cfs_frame_writer_sva i_sva (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .frame_we_out(frame_we_out), .frame_out(frame_out), .synced_out(synced_out),
  .write_mode_out(write_mode_out), .aborted_out(aborted_out));
`default_nettype wire

// file: tb/cfs_host_model.sv
/* Host controller model driving the configuration port pins.
   Assumes the port clock stands low between words, period 800 ns. */
`timescale 1ns/100ps
`default_nettype none
module cfs_host_model
  import cfs_pkg::*;
#(
  parameter logic [15:0] CRC_POLY    = 16'h002d, // Plain default; not the device's polynomial
  parameter bit          LIVE_TABLES = 1'b0      // User design keeps state in lookup tables
)
(
  output logic        port_clk_out,
  output logic        chip_sel_n_out,
  output logic        write_n_out,
  output logic [31:0] port_data_out
);
  logic        in_config = 1'b1;
  int          scrub_gap = 4;
  logic [15:0] exp_crc [$];
  initial begin
    port_clk_out = 1'b0;
    chip_sel_n_out = 1'b1;
    write_n_out = 1'b1;
    port_data_out = 32'h0;
  end
  task automatic pulse();
    #400 port_clk_out = 1'b1;
    #400 port_clk_out = 1'b0;
  endtask
  task automatic send_word(input logic [31:0] w);
    chip_sel_n_out = 1'b0;
    write_n_out = 1'b0;
    port_data_out = w;
    pulse();
  endtask
  task automatic release_port();
    chip_sel_n_out = 1'b1;
    write_n_out = 1'b1;
    // Unselected bus must not keep showing the last word
    port_data_out = ~port_data_out;
    // One idle port period so the next request never lands in this time step
    #800;
  endtask
  task automatic end_config();
    in_config = 1'b0;
  endtask
  // Running CRC restarts per frame and covers its data words only
  function automatic logic [15:0] frame_crc(input logic [FRAME_WORDS*32-1:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int b = 0; b < FRAME_WORDS*32; b++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic abort();
    chip_sel_n_out = 1'b0;
    write_n_out = 1'b1;
    repeat (3) pulse();
    release_port();
  endtask
  // A correction passes frames = 1; frame n carries d with n folded into every word
  task automatic write_frame(input cfs_addr_s a, input logic [FRAME_WORDS*32-1:0] d,
                             input logic write_config_command, input int frames);
    logic [FRAME_WORDS*32-1:0] f;
    if (LIVE_TABLES) return;
    if (!in_config && a.seg != SEG_MAIN) return;
    exp_crc.delete();
    send_word(SYNC_WORD);
    send_word(HDR_CMD);
    send_word(write_config_command ? CMD_WRITE_CONFIG_COMMAND : CMD_RESET_CRC_COMMAND);
    send_word(HDR_FAR);
    send_word({5'h00, a, 9'h000});
    send_word(HDR_FRAME_DATA_INPUT_REGISTER_HI | 32'((frames + 1) * (FRAME_WORDS + 1)));
    for (int n = 0; n < frames; n++) begin
      f = d ^ {FRAME_WORDS{n[31:0]}};
      exp_crc.push_back(frame_crc(f));
      for (int i = 0; i < FRAME_WORDS; i++) send_word(f[i*32 +: 32]);
      send_word(32'h0);
    end
    repeat (FRAME_WORDS + 1) send_word(32'h0);
    release_port();
  endtask
  // Runs in the caller's process, so a scrub never starts while one is running
  task automatic scrub(input cfs_addr_s a, input logic [FRAME_WORDS*32-1:0] d,
                       input int frames);
    int wait_cnt;
    for (wait_cnt = scrub_gap; wait_cnt > 0; wait_cnt--) #800;
    write_frame(a, d, 1'b1, frames);
  endtask
endmodule // cfs_host_model
`default_nettype wire

// file: tb/test_config_frame_scrub_correct.sv
/* Bench for the frame writer: writes, wraps and refusals.
   Assumes the host model's tasks are called from here. */
`timescale 1ns/100ps
`default_nettype none
module test_config_frame_scrub_correct;
  import cfs_pkg::*;
  localparam logic [127:0] PAT = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;
  logic        ref_clk_in;
  logic        rst_in;
  logic        port_clk, cs_n, wr_n;
  logic [31:0] pdata;
  logic        frame_we_out, synced_out, write_mode_out, aborted_out;
  cfs_frame_s  frame_out;
  cfs_frame_s  got[$];
  int          fail_count = 0;
  int          comparisons = 0;
  cfs_frame_writer i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .port_clk_in(port_clk),
    .chip_sel_n_in(cs_n), .write_n_in(wr_n), .port_data_in(pdata),
    .frame_we_out(frame_we_out), .frame_out(frame_out), .synced_out(synced_out),
    .write_mode_out(write_mode_out), .aborted_out(aborted_out));
  cfs_host_model i_host (.port_clk_out(port_clk), .chip_sel_n_out(cs_n),
    .write_n_out(wr_n), .port_data_out(pdata));
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) if (frame_we_out === 1'b1) got.push_back(frame_out);
  task automatic check(input string what, input logic [145:0] seen, input logic [145:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Frame write plus the dummy frame that lands on the next address
  task automatic run_write(input cfs_addr_s a, input cfs_addr_s nxt);
    int n;
    #10;
    got.delete();
    i_host.abort();
    i_host.write_frame(a, PAT, 1'b1, 1);
    for (n = 0; n < 50 && got.size() < 2; n++) @(posedge ref_clk_in);
    if (got.size() < 2) begin
      fail_count++;
      end_sim();
    end
    check("first frame", got[0], {a, PAT});
    check("next addr", 146'(got[1].addr), 146'(nxt));
    check("dummy data", 146'(got[1].data), 146'h0);
    check("write mode", 146'(write_mode_out), 146'h1);
  endtask
  task automatic run_refused();
    #10;
    i_host.abort();
    repeat (4) @(posedge ref_clk_in);
    check("aborted", 146'({aborted_out, synced_out, write_mode_out}), 146'h4);
    got.delete();
    #10;
    i_host.write_frame({SEG_MAIN, 8'h01, 8'h00}, PAT, 1'b0, 1);
    repeat (40) @(posedge ref_clk_in);
    check("refused frames", 146'(got.size()), 146'h0);
    check("resynced", 146'({aborted_out, synced_out}), 146'h1);
  endtask
  // Whole main segment as one run: every frame's address, data and CRC
  task automatic run_scrub();
    int n;
    int k;
    int len;
    int total;
    int bad[$];
    #10;
    total = int'(FR_CENTER) + int'(LOGIC_COLS) * int'(FR_LOGIC) + 2 * int'(FR_IO)
            + 2 * int'(FR_BRAM_IC);
    got.delete();
    i_host.end_config();
    i_host.abort();
    i_host.scrub({SEG_MAIN, 8'h00, 8'h00}, PAT, total);
    for (n = 0; n < 100 && got.size() < total + 1; n++) @(posedge ref_clk_in);
    if (got.size() < total + 1) begin
      fail_count++;
      end_sim();
    end
    k = 0;
    for (int m = 0; m < int'(LOGIC_COLS) + 5; m++) begin
      len = (m == 0) ? int'(FR_CENTER) : (m <= int'(LOGIC_COLS)) ? int'(FR_LOGIC)
          : (m <= int'(LOGIC_COLS) + 2) ? int'(FR_IO) : int'(FR_BRAM_IC);
      for (int f = 0; f < len; f++) begin
        check("scrub addr", 146'(got[k].addr), 146'({SEG_MAIN, 8'(m), 8'(f)}));
        check("scrub data", 146'(got[k].data), 146'(PAT ^ {FRAME_WORDS{k[31:0]}}));
        if (i_host.frame_crc(got[k].data) !== i_host.exp_crc[k]) bad.push_back(k);
        k++;
      end
    end
    check("crc bad frames", 146'(bad.size()), 146'h0);
    check("scrub dummy", 146'(got[total].data), 146'h0);
  endtask
  initial begin
    rst_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #10 rst_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    run_write({SEG_MAIN, 8'h01, 8'h2f}, {SEG_MAIN, 8'h02, 8'h00});
    run_write({SEG_MAIN, 8'h00, 8'h07}, {SEG_MAIN, 8'h01, 8'h00});
    run_write({SEG_BRAM_A, 8'h01, 8'h2f}, {SEG_BRAM_A, 8'h01, 8'h30});
    run_refused();
    run_scrub();
    end_sim();
  end
endmodule // test_config_frame_scrub_correct
`default_nettype wire
